//--- slm_params.svh
`ifndef SLM_PARAMS_SVH
`define SLM_PARAMS_SVH

`define SLM_CLK_HZ 100000000
`define SLM_TOL_MS 100
`define SLM_TOL_CYC ((`SLM_CLK_HZ / 1000) * `SLM_TOL_MS)
`define SLM_TICK_HZ 1
`define SLM_TICK_CYC (`SLM_CLK_HZ / `SLM_TICK_HZ)
`define SLM_CNT_W 32
`define SLM_HIST_DEPTH 8
`define SLM_HIST_AW 3
`define SLM_CNT_RST 32'h0000_0000
`define SLM_INTERVAL_RST 32'h0000_0000

`endif

//--- slm_pkg.sv
`default_nettype none
package slm_pkg;
	typedef enum logic [3:0] {
		SLM_ST_IDLE = 4'b0001,
		SLM_ST_SETTLE = 4'b0010,
		SLM_ST_CHECK = 4'b0100,
		SLM_ST_FAULT = 4'b1000
	} slm_chk_state_t;

	typedef struct packed {
		logic lockout_active;
		logic selection_valid;
		logic channels_differ;
		logic selection_settling;
	} slm_status_t;

	typedef struct packed {
		logic dynamization_overdue_warning;
		logic enabled_standstill_fatal_error;
		logic enabled_standstill_fatal_warning;
		logic input_check_error;
	} slm_diag_t;
endpackage
`default_nettype wire

//--- slm_hist_mem.sv
`timescale 1ns/1ps
`default_nettype none
module slm_hist_mem #(
	parameter int DW = 32,
	parameter int AW = 3
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

//--- slm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "slm_params.svh"

module slm_monitor #(
	parameter int TOL_CYC = `SLM_TOL_CYC,
	parameter int TICK_CYC = `SLM_TICK_CYC,
	parameter int CNT_W = `SLM_CNT_W,
	parameter int HIST_AW = `SLM_HIST_AW
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic drive_enable_i,
	input wire logic sel_ch1_i,
	input wire logic sel_ch2_i,
	input wire logic cfg_nc_no_i,
	input wire logic cfg_warn_only_i,
	input wire logic [CNT_W-1:0] interval_s_i,
	input wire logic [CNT_W-1:0] oper_hours_i,
	input wire logic diag_ack_i,
	input wire logic [HIST_AW-1:0] hist_raddr_i,
	output logic torque_disable_o,
	output logic feedback_nc_o,
	output logic feedback_no_o,
	output slm_pkg::slm_status_t status_o,
	output slm_pkg::slm_diag_t diag_o,
	output logic [CNT_W-1:0] runtime_s_o,
	output logic [CNT_W-1:0] last_lockout_hours_o,
	output logic [HIST_AW:0] hist_count_o,
	output logic [CNT_W-1:0] hist_rdata_o,
	output logic es_warn_logged_o
);
	import slm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [1:0] ch1_sync_reg, ch2_sync_reg, en_sync_reg;
	logic ch1, ch2, drv_en;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ch1_sync_reg <= 2'h0;
		end else begin
			ch1_sync_reg <= {ch1_sync_reg[0], sel_ch1_i};
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ch2_sync_reg <= 2'h0;
		end else begin
			ch2_sync_reg <= {ch2_sync_reg[0], sel_ch2_i};
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			en_sync_reg <= 2'h0;
		end else begin
			en_sync_reg <= {en_sync_reg[0], drive_enable_i};
		end
	end
	assign ch1 = ch1_sync_reg[1];
	assign ch2 = ch2_sync_reg[1];
	assign drv_en = en_sync_reg[1];

	////////////////////////////////////////////////////////////////////////
	// channel decoding
	// a n/c contact opens (reads low) to select; in n/c-n/o mode ch2 closes
	function automatic logic ch2_selects(input logic v, input logic nc_no);
		ch2_selects = nc_no ? v : ~v;
	endfunction

	logic sel1, sel2, agree, selected;
	assign sel1 = ~ch1;
	assign sel2 = ch2_selects(ch2, cfg_nc_no_i);
	assign agree = (sel1 == sel2);

	////////////////////////////////////////////////////////////////////////
	// plausibility check
	slm_chk_state_t chk_reg;
	logic [31:0] tol_cnt_reg;
	logic sel_state_reg;
	logic prev_sel1_reg, prev_sel2_reg;
	logic sel_change;

	assign sel_change = (sel1 != prev_sel1_reg) || (sel2 != prev_sel2_reg);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_sel1_reg <= 1'b1;
			prev_sel2_reg <= 1'b1;
		end else begin
			prev_sel1_reg <= sel1;
			prev_sel2_reg <= sel2;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			chk_reg <= SLM_ST_IDLE;
			tol_cnt_reg <= 32'h0;
		end else begin
			unique case (chk_reg)
				SLM_ST_IDLE: begin
					chk_reg <= SLM_ST_SETTLE;
					tol_cnt_reg <= 32'h0;
				end
				SLM_ST_SETTLE: begin
					if (sel_change) begin
						tol_cnt_reg <= 32'h0;
					end else if (tol_cnt_reg >= 32'(TOL_CYC - 1)) begin
						chk_reg <= agree ? SLM_ST_CHECK : SLM_ST_FAULT;
					end else begin
						tol_cnt_reg <= tol_cnt_reg + 32'h1;
					end
				end
				SLM_ST_CHECK: begin
					if (sel_change) begin
						chk_reg <= SLM_ST_SETTLE;
						tol_cnt_reg <= 32'h0;
					end
				end
				SLM_ST_FAULT: begin
					// latched until channels agree and the fault is acknowledged
					if (agree && diag_ack_i) begin
						chk_reg <= SLM_ST_SETTLE;
						tol_cnt_reg <= 32'h0;
					end
				end
			endcase
		end
	end

	// a latched discrepancy forces lockout; otherwise the last agreed selection holds
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_state_reg <= 1'b1;
		end else if (chk_reg == SLM_ST_FAULT) begin
			sel_state_reg <= 1'b1;
		end else if (agree) begin
			sel_state_reg <= sel1;
		end
	end
	assign selected = sel_state_reg;

	////////////////////////////////////////////////////////////////////////
	// run-time counter in seconds
	logic [31:0] tick_cnt_reg;
	logic tick;
	logic [CNT_W-1:0] runtime_reg;
	logic sel_prev_reg;
	logic sel_rise;

	assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));
	assign sel_rise = selected && !sel_prev_reg;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt_reg <= 32'h0;
		end else if (!drv_en || tick) begin
			tick_cnt_reg <= 32'h0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			runtime_reg <= `SLM_CNT_RST;
		end else if (selected) begin
			runtime_reg <= `SLM_CNT_RST;
		end else if (drv_en && tick && runtime_reg != '1) begin
			runtime_reg <= runtime_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_prev_reg <= 1'b1;
		end else begin
			sel_prev_reg <= selected;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			last_lockout_hours_o <= '0;
		end else if (sel_rise) begin
			last_lockout_hours_o <= oper_hours_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interval change history
	logic [CNT_W-1:0] interval_prev_reg;
	logic [HIST_AW-1:0] hist_wptr_reg;
	logic hist_we;

	assign hist_we = (interval_s_i != interval_prev_reg);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			interval_prev_reg <= `SLM_INTERVAL_RST;
			hist_wptr_reg <= '0;
		end else if (hist_we) begin
			interval_prev_reg <= interval_s_i;
			hist_wptr_reg <= hist_wptr_reg + 1'b1;
		end
	end

	// count saturates at the depth while the pointer wraps over the oldest entry
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hist_count_o <= '0;
		end else if (hist_we && hist_count_o != (HIST_AW + 1)'(1 << HIST_AW)) begin
			hist_count_o <= hist_count_o + 1'b1;
		end
	end

	slm_hist_mem #(
		.DW(CNT_W),
		.AW(HIST_AW)
	) slm_hist_mem_inst (
		.clk_i(clk_i),
		.we_i(hist_we),
		.waddr_i(hist_wptr_reg),
		.wdata_i(interval_s_i),
		.raddr_i(hist_raddr_i),
		.rdata_o(hist_rdata_o)
	);

	////////////////////////////////////////////////////////////////////////
	// diagnostics and outputs
	logic bad_sel;
	assign bad_sel = selected && drv_en;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			diag_o <= '0;
			es_warn_logged_o <= 1'b0;
		end else begin
			diag_o.dynamization_overdue_warning <= (interval_s_i != '0) &&
				(runtime_reg > interval_s_i);
			if (bad_sel && !cfg_warn_only_i) begin
				diag_o.enabled_standstill_fatal_error <= 1'b1;
			end else if (diag_ack_i && !drv_en) begin
				diag_o.enabled_standstill_fatal_error <= 1'b0;
			end
			if (bad_sel && cfg_warn_only_i) begin
				diag_o.enabled_standstill_fatal_warning <= 1'b1;
				es_warn_logged_o <= 1'b1;
			end else if (!drv_en) begin
				diag_o.enabled_standstill_fatal_warning <= 1'b0;
			end
			diag_o.input_check_error <= (chk_reg == SLM_ST_FAULT);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			torque_disable_o <= 1'b1;
			feedback_nc_o <= 1'b0;
			feedback_no_o <= 1'b1;
		end else begin
			torque_disable_o <= selected;
			feedback_nc_o <= !selected;
			feedback_no_o <= selected;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			status_o <= '0;
		end else begin
			status_o.lockout_active <= selected;
			status_o.selection_valid <= (chk_reg == SLM_ST_CHECK);
			status_o.channels_differ <= !agree;
			status_o.selection_settling <= (chk_reg == SLM_ST_SETTLE);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			runtime_s_o <= '0;
		end else begin
			runtime_s_o <= runtime_reg;
		end
	end
endmodule
`default_nettype wire

//--- slm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module slm_checker #(parameter int CNT_W = 32) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic drive_enable_i,
	input wire logic cfg_warn_only_i,
	input wire logic [CNT_W-1:0] interval_s_i,
	input wire logic torque_disable_o,
	input wire logic feedback_nc_o,
	input wire logic feedback_no_o,
	input wire slm_pkg::slm_status_t status_o,
	input wire slm_pkg::slm_diag_t diag_o,
	input wire logic [CNT_W-1:0] runtime_s_o
);
	import slm_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	property p_fb; feedback_no_o != feedback_nc_o; endproperty
	a_fb: assert property (p_fb) else $error("fb");
	property p_act; status_o.lockout_active |-> torque_disable_o && feedback_no_o; endproperty
	a_act: assert property (p_act) else $error("act");
	property p_hold; !drive_enable_i [*8] |-> $stable(runtime_s_o) || runtime_s_o == 0; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_clr; runtime_s_o < $past(runtime_s_o) |-> runtime_s_o == 0; endproperty
	a_clr: assert property (p_clr) else $error("clr");
	property p_due; (interval_s_i != 0 && runtime_s_o > interval_s_i) [*4] |->
		diag_o.dynamization_overdue_warning; endproperty
	a_due: assert property (p_due) else $error("due");
	property p_wclr; $fell(drive_enable_i) |->
		##[1:6] !diag_o.enabled_standstill_fatal_warning; endproperty
	a_wclr: assert property (p_wclr) else $error("wclr");
	property p_err; $rose(diag_o.enabled_standstill_fatal_error) |->
		!cfg_warn_only_i ##[0:3] torque_disable_o; endproperty
	a_err: assert property (p_err) else $error("err");
	property p_warn; $rose(diag_o.enabled_standstill_fatal_warning) |->
		cfg_warn_only_i ##[0:3] torque_disable_o; endproperty
	a_warn: assert property (p_warn) else $error("warn");
endmodule
////////////////////////////////////////////////////////////////
bind slm_monitor slm_checker #(.CNT_W(CNT_W)) slm_checker_inst (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .drive_enable_i(drive_enable_i), .cfg_warn_only_i(cfg_warn_only_i),
	.interval_s_i(interval_s_i), .torque_disable_o(torque_disable_o),
	.feedback_nc_o(feedback_nc_o), .feedback_no_o(feedback_no_o), .status_o(status_o),
	.diag_o(diag_o), .runtime_s_o(runtime_s_o));
`default_nettype wire

//--- slm_selector_model.sv
`timescale 1ns/1ps
`default_nettype none
module slm_selector_model (
	input wire logic clk_i,
	input wire logic select_i,
	input wire logic nc_no_i,
	input wire logic [7:0] lag_i,
	output logic sel_ch1_o,
	output logic sel_ch2_o
);
	logic [7:0] cnt_reg = 8'h00;
	logic ch2_reg = 1'b1;
	// second contact is an independent path that may trail the first by lag_i + 1 cycles
	always_ff @(posedge clk_i) begin
		if (ch2_reg == select_i) begin
			cnt_reg <= 8'h00;
		end else if (cnt_reg >= lag_i) begin
			ch2_reg <= select_i;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
	assign sel_ch1_o = !select_i;
	assign sel_ch2_o = nc_no_i ? ch2_reg : !ch2_reg;
endmodule
`default_nettype wire

//--- test_starting_lockout_safety_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module test_starting_lockout_safety_monitor;
	import slm_pkg::*;
	localparam int TOL = 20;
	localparam int TICK = 10;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic en = 1'b0, nc_no = 1'b0, wo = 1'b0, ack = 1'b0, sel = 1'b1, ch1, ch2, tq, fnc, fno, esl;
	logic [31:0] iv = 32'h0, hrs = 32'h0, rt, lh, hd;
	logic [2:0] ra = 3'h0;
	logic [3:0] hc;
	logic [7:0] lag = 8'h00;
	slm_status_t st;
	slm_diag_t dg;
	int n_mismatch = 0, checked = 0, cyc = 0, en_cyc = 0;
	logic [31:0] hq[$];
	slm_selector_model slm_selector_model_inst (.clk_i(clk_i), .select_i(sel), .nc_no_i(nc_no),
		.lag_i(lag), .sel_ch1_o(ch1), .sel_ch2_o(ch2));
	slm_monitor #(.TOL_CYC(TOL), .TICK_CYC(TICK)) slm_monitor_inst (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .drive_enable_i(en), .sel_ch1_i(ch1), .sel_ch2_i(ch2),
		.cfg_nc_no_i(nc_no), .cfg_warn_only_i(wo), .interval_s_i(iv), .oper_hours_i(hrs),
		.diag_ack_i(ack), .hist_raddr_i(ra), .torque_disable_o(tq), .feedback_nc_o(fnc),
		.feedback_no_o(fno), .status_o(st), .diag_o(dg), .runtime_s_o(rt),
		.last_lockout_hours_o(lh), .hist_count_o(hc), .hist_rdata_o(hd), .es_warn_logged_o(esl));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// run-time seconds from the bench's own count of enabled cycles, one tick of slack
	function automatic logic near(input logic [31:0] v);
		return v + 1 >= en_cyc / TICK && v <= en_cyc / TICK + 1;
	endfunction
	task automatic final_report;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		en_cyc <= sel ? 0 : en_cyc + int'(en);
		if (cyc == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'h698b));
		step(12);
		arst_n_i <= 1'b1;
		look(1);
		chk("active", st.lockout_active, 1);
		chk("fb no", fno, 1);
		for (int m = 0; m < 2; m++) begin
			step(1);
			nc_no <= m[0];
			wo <= m[0];
			sel <= 1'b0;
			lag <= 8'($urandom_range(0, TOL / 2));
			iv <= 32'(m * 3 + $urandom_range(1, 3));
			step(1);
			hq.push_back(iv);
			look(2 * TOL);
			chk("active", st.lockout_active, 0);
			chk("fb nc", fnc, 1);
			chk("differ", st.channels_differ, 0);
			chk("valid", st.selection_valid, 1);
			chk("inchk", dg.input_check_error, 0);
			step(1);
			en <= 1'b1;
			look(TICK * 8);
			chk("rt", near(rt), 1);
			chk("due", dg.dynamization_overdue_warning, 1);
			step(1);
			en <= 1'b0;
			look(TICK * 3);
			chk("rt hold", near(rt), 1);
			step(1);
			hrs <= $urandom;
			sel <= 1'b1;
			look(TOL);
			chk("hours", lh, hrs);
			chk("rt clr", rt, 0);
			step(1);
			sel <= 1'b0;
			step(2 * TOL);
			en <= 1'b1;
			step(TOL);
			sel <= 1'b1;
			look(TOL);
			chk("es err", dg.enabled_standstill_fatal_error, !m[0]);
			chk("es warn", dg.enabled_standstill_fatal_warning, m[0]);
			chk("torque", tq, 1);
			step(1);
			en <= 1'b0;
			look(8);
			chk("logged", esl, m[0]);
			step(1);
			ack <= 1'b1;
			step(1);
			ack <= 1'b0;
			look(2);
			chk("err clr", dg.enabled_standstill_fatal_error, 0);
		end
		step(1);
		lag <= 8'(TOL + 10);
		sel <= 1'b0;
		look(TOL + 8);
		chk("inchk", dg.input_check_error, 1);
		chk("forced", tq, 1);
		chk("differ", st.channels_differ, 1);
		chk("settling", st.selection_settling, 0);
		step(TOL);
		ack <= 1'b1;
		ra <= 3'h1;
		step(1);
		ack <= 1'b0;
		look(2);
		chk("inchk clr", dg.input_check_error, 0);
		chk("hist n", hc, hq.size());
		chk("hist d", hd, hq[1]);
		final_report();
	end
endmodule
`default_nettype wire
